// >>> uaof_cfg.svh
/*
  address/opcode match filter constants: register offsets, field positions, codes.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef UAOF_CFG_SVH
`define UAOF_CFG_SVH

`define UAOF_OFS_FILTER 4'h0
`define UAOF_OFS_EVTCFG 4'h1
`define UAOF_OFS_GLOBAL 4'h2
`define UAOF_OFS_COUNT 4'h3

`define UAOF_ADDR_HI 39
`define UAOF_ADDR_LO 3
`define UAOF_OPC_HI 43
`define UAOF_OPC_LO 40
`define UAOF_CLS_HI 47
`define UAOF_CLS_LO 44
`define UAOF_SEL_HI 63
`define UAOF_SEL_LO 61

`define UAOF_FILTER_MASK 64'he000_ffff_ffff_fff8
`define UAOF_FILTER_RESET 64'h0000_0000_0000_0000

`define UAOF_EVT_MATCH 8'h35
`define UAOF_EVT_EN_BIT 22

`define UAOF_SEL_OFF 3'h0
`define UAOF_SEL_ADDR 3'h4
`define UAOF_SEL_OPC 3'h2
`define UAOF_SEL_EITHER 3'h6
`define UAOF_SEL_BOTH 3'h1

`define UAOF_CLS_HOME 4'h0
`define UAOF_CLS_SNOOP 4'h1
`define UAOF_CLS_DATA 4'he

`define UAOF_OPC_DEMAND_FETCH 4'h2
`define UAOF_OPC_WRITEBACK 4'h3
`define UAOF_OPC_PREFETCH_READ 4'h4
`define UAOF_OPC_PREFETCH_OWN 4'h5
`define UAOF_OPC_PREFETCH_FETCH 4'h6
`define UAOF_OPC_OTHER_A 4'h7
`define UAOF_OPC_OTHER_B 4'hf

`endif

// >>> uaof_pkg.sv
/*
  types of the address/opcode match filter.
  assumes the cfg header sits in the same folder.
*/
`include "uaof_cfg.svh"

package uaof_pkg;

  typedef struct packed {
    logic [2:0] match_criteria_select;
    logic [12:0] rsvd_hi;
    logic [3:0] msg_class;
    logic [3:0] opcode;
    logic [36:0] addr;
    logic [2:0] rsvd_lo;
  } uaof_filter_t;

  typedef struct packed {
    logic valid;
    logic [39:0] addr;
    logic [3:0] msg_class;
    logic [3:0] opcode;
  } uaof_txn_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] index;
    logic [63:0] wdata;
  } uaof_reg_req_t;

endpackage : uaof_pkg

// >>> uaof_filter.sv
/*
  uncore address/opcode match filter with one qualified 48-bit counter.
  assumes transactions come from logic on CORE_CLK and register accesses
  arrive as single-cycle strobes from the register access path.
*/
//
// Behaviour
// - the counter's 8-bit event select picks the match event, which is then qualified by the filter.
// - an address match compares request address bits 39:3 with the filter address, ignoring 2:0.
// - filter bits 47:40 are the opcode field, whose low nibble 43:40 is the compared opcode.
// - bits 47:44 select the message class: home request 0, snoop response 1, data response e.
// - opcode values are demand fetch 2, writeback 3, prefetch read 4, prefetch ownership 5, more.
// - bits 63:61 hold the match criteria select, and 000 disables the match hardware.
// - select 100 counts on an address match alone.
// - select 010 counts on an opcode and class match alone.
// - select 110 counts when either the opcode or the address matches.
// - select 001 counts only when opcode and address match together.
// - the counter counts only with its local enable and its global enable bit both set.
`timescale 1ns/1ps
`include "uaof_cfg.svh"

module uaof_filter (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire uaof_pkg::uaof_reg_req_t REG_REQ,
  input wire uaof_pkg::uaof_txn_t TXN,
  output logic [63:0] REG_RDATA,
  output logic REG_RVALID,
  output logic MATCH_PULSE,
  output logic [47:0] COUNT
);

  // register state
  uaof_pkg::uaof_filter_t address_opcode_match_filter;
  uaof_pkg::uaof_filter_t next_address_opcode_match_filter;
  logic [63:0] counter_event_config;
  logic [63:0] next_counter_event_config;
  logic counter_global_enable_bit;
  logic next_counter_global_enable_bit;
  logic [47:0] count;
  logic [47:0] next_count;

  // register access decode
  logic wr_take;
  logic rd_take;
  logic wr_filter;
  logic wr_evtcfg;
  logic wr_global;
  logic wr_count;

  // match criteria select decode
  logic [2:0] sel_code;
  logic sel_off;
  logic sel_addr;
  logic sel_opc;
  logic sel_either;
  logic sel_both;

  // transaction compare
  logic [`UAOF_ADDR_HI-`UAOF_ADDR_LO:0] addr_bit_eq;
  logic txn_valid;
  logic addr_hit;
  logic opcode_hit;
  logic class_hit;
  logic opc_hit;
  logic sel_hit;
  logic event_hit;
  logic local_enable;
  logic count_en;
  logic match_hit;
  logic count_step;

  // output staging
  logic [63:0] next_rdata;
  logic next_rvalid;
  logic next_pulse;
  logic [47:0] next_count_out;

  // one register strobe aimed at one offset
  function automatic logic reg_hit(
    input logic strobe,
    input logic [3:0] index,
    input logic [3:0] offset
  );
    logic r;
    r = strobe && (index == offset);
    return r;
  endfunction : reg_hit

  // one four-bit field of the transaction against the filter
  function automatic logic nibble_hit(
    input logic [3:0] seen,
    input logic [3:0] wanted
  );
    logic r;
    r = (seen == wanted);
    return r;
  endfunction : nibble_hit

  // one select code against the stored selector
  function automatic logic sel_is(
    input logic [2:0] sel,
    input logic [2:0] code
  );
    logic r;
    r = (sel == code);
    return r;
  endfunction : sel_is

  // per-bit address compare; request bits 2:0 never reach it
  genvar gi;
  generate
    for (gi = 0; gi <= `UAOF_ADDR_HI - `UAOF_ADDR_LO; gi++) begin : g_addr_cmp
      assign addr_bit_eq[gi] =
        (TXN.addr[gi + `UAOF_ADDR_LO] == address_opcode_match_filter.addr[gi]);
    end
  endgenerate

  // register strobes count only while the clock enable is high
  always_comb begin
    wr_take = CLK_EN && REG_REQ.wr;
    rd_take = CLK_EN && REG_REQ.rd;
    wr_filter = reg_hit(wr_take, REG_REQ.index, `UAOF_OFS_FILTER);
    wr_evtcfg = reg_hit(wr_take, REG_REQ.index, `UAOF_OFS_EVTCFG);
    wr_global = reg_hit(wr_take, REG_REQ.index, `UAOF_OFS_GLOBAL);
    wr_count = reg_hit(wr_take, REG_REQ.index, `UAOF_OFS_COUNT);
  end

  // match criteria select decode
  always_comb begin
    sel_code = address_opcode_match_filter.match_criteria_select;
    sel_off = sel_is(sel_code, `UAOF_SEL_OFF);
    sel_addr = sel_is(sel_code, `UAOF_SEL_ADDR);
    sel_opc = sel_is(sel_code, `UAOF_SEL_OPC);
    sel_either = sel_is(sel_code, `UAOF_SEL_EITHER);
    sel_both = sel_is(sel_code, `UAOF_SEL_BOTH);
  end

  // transaction qualification
  always_comb begin
    txn_valid = TXN.valid;
    addr_hit = &addr_bit_eq;
    opcode_hit = nibble_hit(TXN.opcode, address_opcode_match_filter.opcode);
    class_hit = nibble_hit(TXN.msg_class, address_opcode_match_filter.msg_class);
    opc_hit = opcode_hit && class_hit;
    // reserved codes decode to none of the five and count nothing
    sel_hit = !sel_off && ((sel_addr && addr_hit) ||
                           (sel_opc && opc_hit) ||
                           (sel_either && (addr_hit || opc_hit)) ||
                           (sel_both && addr_hit && opc_hit));
    event_hit = (counter_event_config[7:0] == `UAOF_EVT_MATCH);
    match_hit = txn_valid &&
                sel_hit && event_hit;
  end

  // both the local and the global enable must be set
  always_comb begin
    local_enable = counter_event_config[`UAOF_EVT_EN_BIT];
    count_en = local_enable && counter_global_enable_bit;
    count_step = CLK_EN &&
                 match_hit && count_en;
  end

  // reserved filter bits are never stored
  always_comb begin
    next_address_opcode_match_filter = address_opcode_match_filter;
    if (wr_filter) begin
      next_address_opcode_match_filter =
        uaof_pkg::uaof_filter_t'(REG_REQ.wdata & `UAOF_FILTER_MASK);
    end
  end

  always_comb begin
    next_counter_event_config = counter_event_config;
    if (wr_evtcfg) begin
      next_counter_event_config = REG_REQ.wdata;
    end
  end

  always_comb begin
    next_counter_global_enable_bit = counter_global_enable_bit;
    if (wr_global) begin
      next_counter_global_enable_bit = REG_REQ.wdata[0];
    end
  end

  // a software write beats a same-cycle match; that increment is lost
  always_comb begin
    next_count = count;
    if (wr_count) begin
      next_count = REG_REQ.wdata[47:0];
    end else if (count_step) begin
      next_count = count + 48'h1;
    end
  end

  // pulse and count copy reach the ports one edge later
  always_comb begin
    next_pulse = count_step;
    next_count_out = count;
  end

  // read answer; unmapped indexes read zero
  always_comb begin
    next_rvalid = rd_take;
    next_rdata = REG_RDATA;
    if (rd_take) begin
      unique case (REG_REQ.index)
        `UAOF_OFS_FILTER: begin
          next_rdata = address_opcode_match_filter & `UAOF_FILTER_MASK;
        end
        `UAOF_OFS_EVTCFG: begin
          next_rdata = counter_event_config;
        end
        `UAOF_OFS_GLOBAL: begin
          next_rdata = {63'h0, counter_global_enable_bit};
        end
        `UAOF_OFS_COUNT: begin
          next_rdata = {16'h0, count};
        end
        default: begin
          next_rdata = 64'h0;
        end
      endcase
    end
  end

  // filter register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      address_opcode_match_filter <= uaof_pkg::uaof_filter_t'(`UAOF_FILTER_RESET);
    end else if (CLK_EN) begin
      address_opcode_match_filter <= next_address_opcode_match_filter;
    end
  end

  // local counter configuration
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      counter_event_config <= 64'h0;
    end else if (CLK_EN) begin
      counter_event_config <= next_counter_event_config;
    end
  end

  // global enable bit
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      counter_global_enable_bit <= 1'b0;
    end else if (CLK_EN) begin
      counter_global_enable_bit <= next_counter_global_enable_bit;
    end
  end

  // qualified counter
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      count <= 48'h0;
    end else if (CLK_EN) begin
      count <= next_count;
    end
  end

  // match pulse port
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      MATCH_PULSE <= 1'b0;
    end else if (CLK_EN) begin
      MATCH_PULSE <= next_pulse;
    end
  end

  // counter copy port
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      COUNT <= 48'h0;
    end else if (CLK_EN) begin
      COUNT <= next_count_out;
    end
  end

  // read valid port
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RVALID <= 1'b0;
    end else if (CLK_EN) begin
      REG_RVALID <= next_rvalid;
    end
  end

  // read data port, held until the next read
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 64'h0;
    end else if (CLK_EN) begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule : uaof_filter

// >>> uaof_filter_checker.sv
/* port checks of the match filter.
  assumes binding to uaof_filter. */
`timescale 1ns/1ps
module uaof_filter_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire uaof_pkg::uaof_reg_req_t REG_REQ,
  input wire uaof_pkg::uaof_txn_t TXN,
  input wire logic [63:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic MATCH_PULSE,
  input wire logic [47:0] COUNT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  rd_answer_a: assert property (CLK_EN && REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered");
  rd_quiet_a: assert property (CLK_EN && !REG_REQ.rd |=> !REG_RVALID)
    else $error("answer without read");
  rsvd_zero_a: assert property (REG_RVALID && $past(REG_REQ.index) == 4'h0
    |-> REG_RDATA[2:0] == 3'h0 && REG_RDATA[60:48] == 13'h0) else $error("reserved bits set");
  rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
    else $error("read data moved");
  pulse_cause_a: assert property (MATCH_PULSE |-> $past(TXN.valid || !CLK_EN))
    else $error("pulse without transaction");
  count_step_a: assert property (MATCH_PULSE && CLK_EN && $past(CLK_EN && !REG_REQ.wr)
    |=> COUNT == $past(COUNT) + 48'h1) else $error("count not stepped");
  no_count_a: assert property (!MATCH_PULSE && $past(!REG_REQ.wr) |=> $stable(COUNT))
    else $error("count moved");
  freeze_a: assert property (!CLK_EN |=> $stable(COUNT) && $stable(MATCH_PULSE))
    else $error("state moved while frozen");
endmodule : uaof_filter_checker

bind uaof_filter uaof_filter_checker u_chk (.CORE_CLK, .RST, .CLK_EN, .REG_REQ, .TXN,
  .REG_RDATA, .REG_RVALID, .MATCH_PULSE, .COUNT);

// >>> tb_top.sv
/* self-checking bench of the match filter.
  assumes the package and design are compiled first. */
`timescale 1ns/1ps
module tb_top;
  logic CORE_CLK = 0, RST = 1, CLK_EN = 1;
  uaof_pkg::uaof_reg_req_t REG_REQ = '0;
  uaof_pkg::uaof_txn_t TXN = '0;
  logic [63:0] REG_RDATA;
  logic REG_RVALID, MATCH_PULSE;
  logic [47:0] COUNT;
  logic [64:0] q[$];
  logic pq[$];
  logic [64:0] rq;
  logic tv = 1'b0;
  logic g;
  logic [39:0] a;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  logic [2:0] sel [7] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h1, 3'h4};
  int ex [7] = '{0, 2, 2, 3, 1, 1, 0};
  logic [3:0] opc [7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
  logic [3:0] cls [3] = '{4'h0, 4'h1, 4'he};
  uaof_filter u_dut (.CORE_CLK, .RST, .CLK_EN, .REG_REQ, .TXN, .REG_RDATA, .REG_RVALID,
    .MATCH_PULSE, .COUNT);
  always #10 CORE_CLK = ~CORE_CLK;
  task wr(input logic [3:0] i, input logic [63:0] d);
    @(posedge CORE_CLK) REG_REQ <= '{1'b1, 1'b0, i, d};
    @(posedge CORE_CLK) REG_REQ <= '0;
  endtask : wr
  task rd(input logic [3:0] i, input logic [63:0] e);
    q.push_back({i == 4'h3, e});
    @(posedge CORE_CLK) REG_REQ <= '{1'b0, 1'b1, i, 64'h0};
    @(posedge CORE_CLK) REG_REQ <= '0;
  endtask : rd
  task tx(input logic [39:0] ad, input logic [3:0] c, input logic [3:0] o, input logic e);
    pq.push_back(e);
    @(posedge CORE_CLK) TXN <= '{1'b1, ad, c, o};
  endtask : tx
  task chk(input logic [63:0] e);
    comparisons++;
    if (REG_RDATA !== e) begin
      n_mismatch++;
      $display("mismatch %0t read %h expected %h", $time, REG_RDATA, e);
    end
  endtask : chk
  task chk_count(input logic [47:0] e);
    comparisons++;
    if (COUNT !== e) begin
      n_mismatch++;
      $display("mismatch %0t count %h expected %h", $time, COUNT, e);
    end
  endtask : chk_count
  task chk_pulse(input logic e);
    comparisons++;
    if (MATCH_PULSE !== e) begin
      n_mismatch++;
      $display("mismatch %0t pulse %b expected %b", $time, MATCH_PULSE, e);
    end
  endtask : chk_pulse
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge CORE_CLK) begin
    cyc++;
    if (REG_RVALID === 1'b1) begin
      rq = q.size() > 0 ? q.pop_front() : 65'hx;
      chk(rq[63:0]);
      if (rq[64] !== 1'b0) chk_count(rq[47:0]);
    end
    if (tv) chk_pulse(pq.size() > 0 ? pq.pop_front() : 1'bx);
    tv = TXN.valid;
    if (cyc > 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hac71dc64));
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK) CLK_EN <= 1'b0;
    @(posedge CORE_CLK) CLK_EN <= 1'b1;
    rd(4'h0, 64'h0);
    rd(4'h9, 64'h0);
    wr(4'h0, '1);
    rd(4'h0, 64'he000_ffff_ffff_fff8);
    wr(4'h1, 64'h40_0035);
    for (int k = 0; k < 7; k++) begin
      a = 40'({$urandom(), $urandom()});
      g = k < 6;
      wr(4'h2, {63'h0, g});
      wr(4'h3, 64'h0);
      wr(4'h0, {sel[k], 13'h0, cls[k % 3], opc[k], a[39:3], 3'h0});
      tx(a ^ 40'h7, cls[k % 3], opc[k], sel[k] != 3'h0 && g);
      tx(a, ~cls[k % 3], opc[k], (sel[k] == 3'h4 || sel[k] == 3'h6) && g);
      tx(a ^ 40'h8, cls[k % 3], opc[k], (sel[k] == 3'h2 || sel[k] == 3'h6) && g);
      tx(a ^ 40'h10, cls[k % 3], ~opc[k], 1'b0);
      @(posedge CORE_CLK) TXN <= '0;
      rd(4'h3, 64'(ex[k]));
    end
    repeat (2) @(posedge CORE_CLK);
    end_of_test();
  end
endmodule : tb_top
